/* File: logic/asc_pkg.sv */
/*
  Constants for the serial conversion controller: frame layout,
  input word fields, reset values and timing counts.
  Assumes a 40 MHz system clock.
*/
`default_nettype none
package asc_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 25;
  // Conversion time at 1x; plain default, analog core sets the truth
  localparam int CONV_1X_NS    = 1000000;
  localparam int CONV_1X_CYC   = CONV_1X_NS / CLK_PERIOD_NS;

  // ****************************************
  // Frame and input word
  // ****************************************
  localparam int FRAME_BITS    = 24;
  localparam int IN_BITS       = 16;
  localparam int RES_W         = 17;
  localparam int FIFO_DEPTH    = 8;
  localparam logic [4:0] CNT_CH   = 5'h08;
  localparam logic [4:0] CNT_CFG  = 5'h10;
  localparam logic [4:0] CNT_LAST = 5'h17;
  localparam logic [2:0] EN_PATTERN = 3'h5;
  localparam int POS_EN_HI     = 15;
  localparam int POS_EN_LO     = 13;
  localparam int POS_CH_HI     = 12;
  localparam int POS_CH_LO     = 8;
  localparam int POS_CFG_EN    = 7;
  localparam int POS_TEMP      = 6;
  localparam int POS_REJ_HI    = 5;
  localparam int POS_REJ_LO    = 4;
  localparam int POS_SPD       = 3;
  localparam int POS_GAIN_HI   = 2;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [4:0] RST_CHAN = 5'h00;
  localparam logic [1:0] RST_REJ  = 2'h0;
  localparam logic [2:0] RST_GAIN = 3'h0;

  typedef enum logic [2:0] {
    ST_CONV  = 3'b001,
    ST_SLEEP = 3'b010,
    ST_XFER  = 3'b100
  } asc_state_t;

endpackage
`default_nettype wire

/* File: logic/asc_ctrl.sv */
/*
  Serial interface and conversion-cycle control of a 16-bit
  converter, plus the result FIFO between core and shifter.
  Assumes serial pins arrive asynchronously and the analog core
  pushes results over a valid/ready port.
*/
`timescale 1ns/10ps
`default_nettype none

// ****************************************
// Result FIFO
// ****************************************
module asc_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign o_ready = (cnt_q != (AW+1)'(D));
  assign o_valid = (cnt_q != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem_q[rd_q];

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ****************************************
// Controller
// ****************************************
module asc_ctrl
  import asc_pkg::*;
#(
  parameter int P_CONV_CYC = CONV_1X_CYC
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_cs_n,
  input  wire logic             i_sck,
  input  wire logic             i_sdi,
  input  wire logic             i_oscillator_pin,
  output logic                  o_sdo,
  output logic                  o_sdo_oe,
  input  wire logic             i_res_valid,
  output logic                  o_res_ready,
  input  wire logic [RES_W-1:0] i_res_data,
  output logic                  o_conv_start,
  output logic [4:0]            o_chan,
  output logic                  o_temp_input_sel,
  output logic [1:0]            o_line_reject_sel,
  output logic                  o_rate_double_sel,
  output logic                  o_autocal_en,
  output logic [2:0]            o_gain_sel,
  output logic [3:0]            o_gain_log2,
  output logic                  o_osc_ext,
  output logic                  o_int_sck_mode,
  output logic                  o_sleep
);
  // ****************************************
  // Pin synchronisers and edges
  // ****************************************
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic       sck_p_q;
  logic       cs_p_q;
  logic       cs_n_s;
  logic       sck_s;
  logic       sdi_s;
  logic       sck_rise;
  logic       sck_fall;
  logic       cs_rise;
  logic       cs_fall;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // Serial clock resets to its idle low level: no false edge
      s1_q    <= 4'hD;
      s2_q    <= 4'hD;
      sck_p_q <= 1'b0;
      cs_p_q  <= 1'b1;
    end else begin
      s1_q    <= {i_oscillator_pin, i_sdi, i_sck, i_cs_n};
      s2_q    <= s1_q;
      sck_p_q <= s2_q[1];
      cs_p_q  <= s2_q[0];
    end
  end

  assign cs_n_s   = s2_q[0];
  assign sck_s    = s2_q[1];
  assign sdi_s    = s2_q[2];
  assign sck_rise = sck_s && !sck_p_q;
  assign sck_fall = !sck_s && sck_p_q;
  assign cs_rise  = cs_n_s && !cs_p_q;
  assign cs_fall  = !cs_n_s && cs_p_q;
  assign o_osc_ext = s2_q[3];

  // ****************************************
  // Clock mode strap
  // ****************************************
  // Strap taken three cycles after release, once synchronisers settle
  logic       strap_done_q;
  logic [1:0] strap_wait_q;
  logic       int_mode_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_wait_q <= 2'h0;
      strap_done_q <= 1'b0;
      int_mode_q   <= 1'b0;
    end else if (!strap_done_q) begin
      strap_wait_q <= strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h2) begin
        strap_done_q <= 1'b1;
        int_mode_q   <= sck_s;
      end
    end else if (cs_fall) begin
      int_mode_q <= sck_s;
    end
  end

  assign o_int_sck_mode = int_mode_q;

  // ****************************************
  // Result FIFO
  // ****************************************
  logic             rf_valid;
  logic             rf_ready;
  logic [RES_W-1:0] rf_data;

  asc_fifo #(
    .W (RES_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_valid (i_res_valid),
    .o_ready (o_res_ready),
    .i_data  (i_res_data),
    .o_valid (rf_valid),
    .i_ready (rf_ready),
    .o_data  (rf_data)
  );

  // ****************************************
  // Conversion cycle state
  // ****************************************
  asc_state_t st_q;
  logic [31:0] cnt_q;
  logic [4:0]  nfall_q;
  logic [4:0]  nrise_q;
  logic        conv_done;
  logic        frame_end;
  logic        abort;
  logic        start;
  logic        wake;

  // Conversion waits on the core; an empty FIFO stretches it
  assign conv_done = (st_q == ST_CONV) && (cnt_q == '0) && rf_valid;
  assign rf_ready  = conv_done;
  assign wake      = (st_q == ST_SLEEP) && sck_rise && !cs_n_s
                     && !int_mode_q && strap_done_q;
  assign frame_end = (st_q == ST_XFER) && sck_fall
                     && (nfall_q == CNT_LAST);
  assign abort     = (st_q == ST_XFER) && cs_rise;
  assign start     = frame_end || abort;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= ST_CONV;
    end else begin
      unique case (st_q)
        ST_CONV: begin
          if (conv_done) begin
            st_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake) begin
            st_q <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (start) begin
            st_q <= ST_CONV;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Shift registers and edge counts
  // ****************************************
  logic [FRAME_BITS-1:0] out_q;
  logic [IN_BITS-1:0]    in_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_q   <= '0;
      in_q    <= '0;
      nfall_q <= '0;
      nrise_q <= '0;
    end else begin
      if (conv_done) begin
        // Flag low, spare zero, sign and data, zero pad
        out_q   <= {2'b00, rf_data, 5'h00};
        nfall_q <= '0;
        nrise_q <= '0;
      end else if (wake || (st_q == ST_XFER && sck_rise)) begin
        if (nrise_q < 5'(IN_BITS)) begin
          in_q[4'(IN_BITS - 1 - int'(nrise_q))] <= sdi_s;
        end
        if (nrise_q != 5'h1F) begin
          nrise_q <= nrise_q + 5'h01;
        end
      end else if (st_q == ST_XFER && sck_fall) begin
        out_q   <= {out_q[FRAME_BITS-2:0], 1'b0};
        nfall_q <= nfall_q + 5'h01;
      end
    end
  end

  // ****************************************
  // Channel and configuration
  // ****************************************
  logic [4:0] chan_q;
  logic       temp_q;
  logic [1:0] rej_q;
  logic       spd_q;
  logic [2:0] gain_q;
  logic       ch_ok;
  logic       cfg_ok;
  logic       ld_ch;
  logic       ld_cfg;

  assign ch_ok  = in_q[POS_EN_HI:POS_EN_LO] == EN_PATTERN;
  assign cfg_ok = ch_ok && in_q[POS_CFG_EN];
  assign ld_ch  = start && ch_ok && (frame_end || nfall_q >= CNT_CH);
  assign ld_cfg = start && cfg_ok && (frame_end || nfall_q >= CNT_CFG);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chan_q <= RST_CHAN;
      temp_q <= 1'b0;
      rej_q  <= RST_REJ;
      spd_q  <= 1'b0;
      gain_q <= RST_GAIN;
    end else begin
      if (ld_ch) begin
        chan_q <= in_q[POS_CH_HI:POS_CH_LO];
      end
      if (ld_cfg) begin
        temp_q <= in_q[POS_TEMP];
        rej_q  <= in_q[POS_REJ_HI:POS_REJ_LO];
        spd_q  <= in_q[POS_SPD];
        gain_q <= in_q[POS_GAIN_HI:0];
      end
    end
  end

  // ****************************************
  // Settings to the core, latched one cycle after start
  // ****************************************
  // Latching here keeps a mid-frame load off the running conversion
  logic eff_dbl;
  logic conv_go_q;

  assign eff_dbl = spd_q && !temp_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      conv_go_q         <= 1'b0;
      o_chan            <= RST_CHAN;
      o_temp_input_sel  <= 1'b0;
      o_line_reject_sel <= RST_REJ;
      o_rate_double_sel <= 1'b0;
      o_autocal_en      <= 1'b1;
      o_gain_sel        <= RST_GAIN;
      o_gain_log2       <= 4'h0;
    end else begin
      conv_go_q <= start;
      if (conv_go_q) begin
        o_chan            <= chan_q;
        o_temp_input_sel  <= temp_q;
        o_line_reject_sel <= rej_q;
        o_rate_double_sel <= eff_dbl;
        o_autocal_en      <= !eff_dbl;
        o_gain_sel        <= gain_q;
        // 1x skips gain 2; 2x tops out at 128
        if (eff_dbl || gain_q == 3'h0) begin
          o_gain_log2 <= {1'b0, gain_q};
        end else begin
          o_gain_log2 <= {1'b0, gain_q} + 4'h1;
        end
      end
    end
  end

  assign o_conv_start = conv_go_q;

  // Counter reloads with start; core result is settled per cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 32'(P_CONV_CYC - 1);
    end else if (start) begin
      cnt_q <= eff_dbl ? 32'(P_CONV_CYC / 2 - 1)
                       : 32'(P_CONV_CYC - 1);
    end else if (st_q == ST_CONV && cnt_q != '0) begin
      cnt_q <= cnt_q - 32'h1;
    end
  end

  // ****************************************
  // Data output pin
  // ****************************************
  assign o_sdo_oe = !cs_n_s;
  assign o_sdo    = (st_q == ST_CONV) ? 1'b1
                    : out_q[FRAME_BITS-1];
  assign o_sleep  = (st_q == ST_SLEEP);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sdo_hiz_a: assert property (cs_n_s |-> !o_sdo_oe)
    else $error("data output driven with select high");
  eoc_busy_a: assert property (
    o_sdo_oe && st_q == ST_CONV |-> o_sdo)
    else $error("flag not high during conversion");
  eoc_idle_a: assert property (
    o_sdo_oe && st_q == ST_SLEEP |-> !o_sdo)
    else $error("flag not low while asleep");
  done_sleep_a: assert property (conv_done |=> o_sleep)
    else $error("no sleep after conversion end");
  sleep_hold_a: assert property (
    st_q == ST_SLEEP && !sck_rise |=> st_q == ST_SLEEP)
    else $error("left sleep without clock edge");
  end_frame_a: assert property (
    frame_end |=> st_q == ST_CONV && o_sdo && o_conv_start)
    else $error("24th fall did not start conversion");
  abort_conv_a: assert property (abort |=> st_q == ST_CONV)
    else $error("abort did not start conversion");
  early_keep_a: assert property (
    abort && nfall_q < CNT_CH |=> $stable(chan_q))
    else $error("channel changed on early abort");
  mid_keep_a: assert property (
    abort && nfall_q < CNT_CFG |=> $stable(gain_q) && $stable(spd_q))
    else $error("configuration changed on mid abort");
  temp_rate_a: assert property (
    o_temp_input_sel |-> !o_rate_double_sel && o_autocal_en)
    else $error("temperature conversion not at 1x");
  bad_en_a: assert property (
    start && !ch_ok |=> $stable(chan_q))
    else $error("channel loaded without enable pattern");

  full_frame_c: cover property (frame_end);
  late_abort_c: cover property (abort && nfall_q >= CNT_CFG);
  dbl_conv_c: cover property (o_conv_start && o_rate_double_sel);
  fifo_stall_c: cover property (st_q == ST_CONV && cnt_q == '0 && !rf_valid);

endmodule
`default_nettype wire

/* File: tb/asc_host.sv */
/*
  Host model: drives select, serial clock and data in, reads data out.
  Assumes a 40 MHz bench clock; one serial bit spans 8 cycles.
*/
`timescale 1ns/10ps
`default_nettype none
module asc_host (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  output logic      o_cs_n,
  output logic      o_sck,
  output logic      o_sdi
);
  // ****************************************
  // Link tasks
  // ****************************************
  initial begin
    o_cs_n = 1'b1;
    o_sck  = 1'b0;
    o_sdi  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic set_cs(input logic v);
    @(posedge i_clk);
    o_cs_n <= v;
    wait_clk(4);
  endtask

  // Clock level at select fall picks the mode
  task automatic mode(input logic s);
    @(posedge i_clk);
    o_sck <= s;
    wait_clk(4);
    set_cs(1'b0);
    set_cs(1'b1);
    o_sck <= 1'b0;
    wait_clk(4);
  endtask

  // Read late in the high phase: output stands there, clear of its update
  task automatic xfer(input logic [15:0] w, input int nf, output logic [23:0] r);
    logic [15:0] s;
    s = w;
    r = '0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_sdi  <= s[15];
    wait_clk(4);
    for (int i = 0; i < 24; i++) begin
      o_sck <= 1'b1;
      wait_clk(4);
      r[23-i] = i_sdo;
      s = {s[14:0], ~s[15]};
      o_sck <= 1'b0;
      o_sdi <= s[15];
      wait_clk(4);
      // A full frame keeps select low so the busy flag can be seen
      if (i + 1 == nf && nf < 24) begin
        o_cs_n <= 1'b1;
        wait_clk(1);
        return;
      end
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/asc_ctrl_tb_top.sv */
/*
  Testbench of the serial conversion controller: reset, table of frames,
  then abort, clock-mode and oscillator cases.
  Assumes the host model and a core feeder that keeps the FIFO full except in the mid-reset stall case.
*/
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module asc_ctrl_tb_top;
  import asc_pkg::*;
  typedef struct packed {
    logic [15:0] w;
    logic [4:0]  ch;
    logic        tp;
    logic [1:0]  rj;
    logic        rd;
    logic [2:0]  gs;
  } asc_row_t;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic             i_clk, i_rst_n, cs_n, sck, sdi, osc_pin, res_valid, res_ready;
  logic             sdo, sdo_oe, sdo_w, conv_start, tp, rd, autocal, osc_ext, int_mode;
  logic             sleep;
  logic             sdo_hold = 1'b0;
  logic [RES_W-1:0] res_data;
  logic [4:0]       chan;
  logic [1:0]       rj;
  logic [2:0]       gs;
  logic [3:0]       lg;
  int               errors, cmp_count, push_cnt, pop;
  // Log2 of the 1x gains 1, 4, 8 .. 256
  localparam logic [3:0] LG1X [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};

  function automatic logic [RES_W-1:0] res_word(input int n);
    return {n[0], 8'hC3 ^ n[7:0], n[7:0]};
  endfunction
  function automatic logic [15:0] mk(input logic en, input logic [4:0] c, input logic e2,
    input logic im, input logic [1:0] r, input logic sp, input logic [2:0] g);
    return {2'b10, en, c, e2, im, r, sp, g};
  endfunction

  // Released data line shows the inverse of its last driven level
  always @(posedge i_clk) if (sdo_oe) sdo_hold <= sdo;
  assign sdo_w = sdo_oe ? sdo : ~sdo_hold;
  assign res_data = res_word(push_cnt);
  always @(posedge i_clk) if (res_valid && res_ready) push_cnt <= push_cnt + 1;

  asc_host asc_host_inst (.i_clk(i_clk), .i_sdo(sdo_w), .o_cs_n(cs_n), .o_sck(sck), .o_sdi(sdi));
  asc_ctrl #(.P_CONV_CYC(64)) asc_ctrl_inst (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_cs_n(cs_n),
    .i_sck(sck), .i_sdi(sdi), .i_oscillator_pin(osc_pin), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .i_res_valid(res_valid), .o_res_ready(res_ready), .i_res_data(res_data),
    .o_conv_start(conv_start), .o_chan(chan), .o_temp_input_sel(tp), .o_line_reject_sel(rj),
    .o_rate_double_sel(rd), .o_autocal_en(autocal), .o_gain_sel(gs), .o_gain_log2(lg),
    .o_osc_ext(osc_ext), .o_int_sck_mode(int_mode), .o_sleep(sleep));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wait_sleep();
    for (int i = 0; i < 2000 && sleep !== 1'b1; i++) @(negedge i_clk);
    `CHK("sleep", 1'b1, sleep)
  endtask

  task automatic run_row(input asc_row_t r, input int nf);
    logic [23:0] fr;
    wait_sleep();
    asc_host_inst.xfer(r.w, nf, fr);
    if (nf == FRAME_BITS) begin
      `CHK("frame", {2'b00, res_word(pop), 5'h00}, fr)
      asc_host_inst.wait_clk(2);
      `CHK("busy flag", 1'b1, sdo_w)
      asc_host_inst.set_cs(1'b1);
      `CHK("sdo release", 1'b0, sdo_oe)
    end else begin
      for (int i = 0; i < 10 && conv_start !== 1'b1; i++) @(negedge i_clk);
      `CHK("abort start", 1'b1, conv_start)
    end
    pop++;
    wait_sleep();
    `CHK("chan", r.ch, chan)
    `CHK("temp", r.tp, tp)
    `CHK("reject", r.rj, rj)
    `CHK("rate", r.rd, rd)
    `CHK("autocal", ~r.rd, autocal)
    `CHK("gain", r.gs, gs)
    `CHK("gain log2", r.rd ? {1'b0, r.gs} : LG1X[r.gs], lg)
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  localparam asc_row_t ROWS [7] = '{
    '{mk(1, 5'h11, 1, 0, 2'h1, 0, 3'h0), 5'h11, 0, 2'h1, 0, 3'h0},
    '{mk(1, 5'h03, 1, 0, 2'h2, 0, 3'h7), 5'h03, 0, 2'h2, 0, 3'h7},
    '{mk(1, 5'h1A, 1, 0, 2'h0, 1, 3'h5), 5'h1A, 0, 2'h0, 1, 3'h5},
    '{mk(1, 5'h05, 1, 1, 2'h1, 1, 3'h0), 5'h05, 1, 2'h1, 0, 3'h0},
    '{mk(0, 5'h1F, 1, 1, 2'h3, 1, 3'h7), 5'h05, 1, 2'h1, 0, 3'h0},
    '{mk(1, 5'h07, 0, 0, 2'h2, 1, 3'h6), 5'h07, 1, 2'h1, 0, 3'h0},
    '{16'h7FFF, 5'h07, 1, 2'h1, 0, 3'h0}
  };

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    repeat (60000) @(posedge i_clk);
    errors++;
    $display("watchdog expired");
    end_sim();
  end

  initial begin
    i_rst_n = 1'b0;
    osc_pin = 1'b0;
    res_valid = 1'b0;
    repeat (4) @(negedge i_clk);
    `CHK("rst oe", 1'b0, sdo_oe)
    `CHK("rst chan", RST_CHAN, chan)
    `CHK("rst autocal", 1'b1, autocal)
    `CHK("rst mode", 1'b0, int_mode)
    `CHK("rst sleep", 1'b0, sleep)
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    res_valid <= 1'b1;
    repeat (20) @(negedge i_clk);
    `CHK("fifo fill", FIFO_DEPTH, push_cnt)
    `CHK("fifo full", 1'b0, res_ready)
    `CHK("osc int", 1'b0, osc_ext)
    asc_host_inst.set_cs(1'b0);
    `CHK("conv flag", 1'b1, sdo_w)
    wait_sleep();
    `CHK("done flag", 1'b0, sdo_w)
    $display("test reset done");
    foreach (ROWS[k]) run_row(ROWS[k], FRAME_BITS);
    $display("test table done");
    for (int s = 0; s < 2; s++) begin
      for (int g = 0; g < 8; g++) begin
        run_row(asc_row_t'{mk(1, 5'h00, 1, 0, 2'h0, s[0], g[2:0]), 5'h00, 0, 2'h0, s[0], g[2:0]},
          FRAME_BITS);
      end
    end
    $display("test gains done");
    run_row(asc_row_t'{mk(1, 5'h0B, 1, 1, 2'h2, 0, 3'h1), 5'h00, 0, 2'h0, 1, 3'h7}, 7);
    run_row(asc_row_t'{mk(1, 5'h0B, 1, 1, 2'h2, 0, 3'h1), 5'h0B, 0, 2'h0, 1, 3'h7}, 8);
    run_row(asc_row_t'{mk(1, 5'h0B, 1, 1, 2'h2, 0, 3'h1), 5'h0B, 1, 2'h2, 0, 3'h1}, 16);
    $display("test abort done");
    asc_host_inst.mode(1'b1);
    `CHK("int mode", 1'b1, int_mode)
    asc_host_inst.mode(1'b0);
    `CHK("ext mode", 1'b0, int_mode)
    @(posedge i_clk);
    osc_pin <= 1'b1;
    repeat (6) @(negedge i_clk);
    `CHK("osc ext", 1'b1, osc_ext)
    $display("test modes done");
    // Mid-run reset empties the FIFO; a starved core stretches conversion
    @(posedge i_clk);
    i_rst_n   <= 1'b0;
    res_valid <= 1'b0;
    @(negedge i_clk);
    pop = push_cnt;
    `CHK("mid rst oe", 1'b0, sdo_oe)
    `CHK("mid rst sleep", 1'b0, sleep)
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (2) @(negedge i_clk);
    `CHK("mid rst start", 1'b0, conv_start)
    repeat (100) @(negedge i_clk);
    `CHK("stall", 1'b0, sleep)
    `CHK("stall mode", 1'b0, int_mode)
    @(posedge i_clk);
    res_valid <= 1'b1;
    run_row(asc_row_t'{mk(1, 5'h0C, 1, 0, 2'h2, 1, 3'h3), 5'h0C, 0, 2'h2, 1, 3'h3},
      FRAME_BITS);
    $display("test mid reset done");
    end_sim();
  end
endmodule
`default_nettype wire
